//--- verilog/vga_adc_gain_sequencing_serial_out.v
/*
 * vga_adc_gain_sequencing_serial_out: digital side of a sixteen-stage
 * variable-gain front end with eight shared converters. serial register
 * programming, time_gain_curve memory and stepping, pair interleaving,
 * fixed conversion latency, fifo, and serial output with bit/frame clocks.
 * assumes analog results arrive as 12-bit words on conv_in each clock,
 * pins are asynchronous to aclk, and an axi4-lite master on aclk.
 */
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
// Behaviour
// - sixteen gain stages share eight converters
// - gain code -5..31 dB, 0.125 dB
// - serial-loaded curve memory shared by stages
// - sync pin starts all stages together
// - software sync acts like pin
// - converter alternates its two stages
// - word emerges 11 clocks after sampling
// - one offset-binary serial lane per channel
// - bit clock and word frame clock
// - selectable filter corner, clamp switch
// - reset pin pulse clears control registers
// - soft reset bit clears, self-clears
// - 24 serial bits committed per group
// - eight address bits, sixteen data bits
// - soft reset is address zero bit zero
`timescale 1ns/1ps
`include "vga_adc_regs.vh"

module vga_adc_gain_sequencing_serial_out (
   input wire aclk,
   input wire aresetn,
   // device pins
   input wire reset_pin,
   input wire sync_pin,
   input wire serial_clk,
   input wire serial_select_n,
   input wire serial_shift_data,
   input wire [95:0] conv_in,
   output reg [7:0] data_lane,
   output reg bit_clk,
   output reg frame_clk,
   output reg [15:0] stage_gain_active,
   output reg [8:0] gain_code,
   output reg [1:0] antialias_filter,
   output reg clamp_enable,
   // axi4-lite slave
   input wire [7:0] s_awaddr,
   input wire s_awvalid,
   output wire s_awready,
   input wire [31:0] s_wdata,
   input wire [3:0] s_wstrb,
   input wire s_wvalid,
   output wire s_wready,
   output reg [1:0] s_bresp,
   output reg s_bvalid,
   input wire s_bready,
   input wire [7:0] s_araddr,
   input wire s_arvalid,
   output wire s_arready,
   output reg [31:0] s_rdata,
   output reg [1:0] s_rresp,
   output reg s_rvalid,
   input wire s_rready
);
   // -----------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------
   reg [4:0] pin_meta; // first stage, read only by pin_sync
   reg [4:0] pin_sync; // second stage
   reg [4:0] pin_last; // for edge detection
   wire rst_s;
   wire sync_s;
   wire sclk_s;
   wire sel_n_s;
   wire sdat_s;
   assign rst_s = pin_sync[0];
   assign sync_s = pin_sync[1];
   assign sclk_s = pin_sync[2];
   assign sel_n_s = pin_sync[3];
   assign sdat_s = pin_sync[4];

   // two-flop capture of all pins
   always @(posedge aclk) begin
      if (!aresetn) begin
         pin_meta <= 5'h08;
         pin_sync <= 5'h08;
         pin_last <= 5'h08;
      end else begin
         pin_meta <= {serial_shift_data, serial_select_n, serial_clk, sync_pin, reset_pin};
         pin_sync <= pin_meta;
         pin_last <= pin_sync;
      end
   end

   wire sclk_rise;
   wire sync_rise;
   assign sclk_rise = sclk_s & ~pin_last[2];
   assign sync_rise = sync_s & ~pin_last[1];

   // -----------------------------------------------------------------
   // control registers
   // -----------------------------------------------------------------
   reg soft_reset; // self-clearing reset request
   reg [1:0] filter_sel; // antialias_filter corner
   reg clamp_off; // clamp disabled
   reg [3:0] curve_len; // last curve entry index
   reg [3:0] curve_wptr; // curve memory write pointer
   reg [8:0] curve_mem [0:`CURVE_DEPTH-1]; // time_gain_curve
   reg [3:0] curve_pos; // current curve entry
   reg curve_run; // stepping active
   reg soft_sync; // software sync pulse
   wire regs_clear;

   assign regs_clear = rst_s | soft_reset;

   // common write port: serial word or axi write
   reg wr_en;
   reg [7:0] wr_addr;
   reg [15:0] wr_data;

   // -----------------------------------------------------------------
   // serial programming shifter
   // -----------------------------------------------------------------
   reg [23:0] ser_shift; // incoming bits
   reg [4:0] ser_count; // bits in current group
   reg ser_commit; // 24-bit group complete
   reg [23:0] ser_word; // committed word

   always @(posedge aclk) begin
      if (!aresetn) begin
         ser_shift <= 24'h000000;
         ser_count <= 5'h00;
         ser_commit <= 1'b0;
         ser_word <= 24'h000000;
      end else begin
         ser_commit <= 1'b0;
         if (sel_n_s) begin
            // select high: restart group count
            ser_count <= 5'h00;
         end else if (sclk_rise) begin
            ser_shift <= {ser_shift[22:0], sdat_s};
            if (ser_count == 5'h17) begin
               ser_count <= 5'h00;
               ser_commit <= 1'b1;
               ser_word <= {ser_shift[22:0], sdat_s};
            end else begin
               ser_count <= ser_count + 5'h01;
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // axi4-lite slave
   // -----------------------------------------------------------------
   reg aw_held; // address captured
   reg w_held; // data captured
   reg [7:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   wire axi_wr;
   assign s_awready = ~aw_held & ~s_bvalid;
   assign s_wready = ~w_held & ~s_bvalid;
   assign s_arready = ~s_rvalid;
   assign axi_wr = aw_held & w_held & ~s_bvalid;

   // write channels, either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_bvalid <= 1'b0;
         s_bresp <= 2'h0;
      end else begin
         if (s_awvalid && s_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_awaddr;
         end
         if (s_wvalid && s_wready) begin
            w_held <= 1'b1;
            w_data <= s_wdata;
            w_strb <= s_wstrb;
         end
         if (axi_wr) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_bvalid <= 1'b1;
            // slverr for any word above curve data, including the read-only status words
            s_bresp <= (aw_addr[7:2] > `REG_CURVE_DATA) ? 2'h2 : 2'h0;
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
         end
      end
   end

   // write port select: serial has priority, an axi write in the same cycle is dropped
   always @* begin
      wr_en = 1'b0;
      wr_addr = 8'h00;
      wr_data = 16'h0000;
      if (ser_commit) begin
         wr_en = 1'b1;
         wr_addr = ser_word[23:16];
         wr_data = ser_word[15:0];
      end else if (axi_wr && (w_strb[1:0] == 2'h3)) begin
         wr_en = 1'b1;
         wr_addr = {2'h0, aw_addr[7:2]};
         wr_data = w_data[15:0];
      end
   end

   // -----------------------------------------------------------------
   // register writes
   // -----------------------------------------------------------------
   // control, filter, clamp and curve control fields
   always @(posedge aclk) begin
      if (!aresetn || regs_clear) begin
         soft_reset <= 1'b0;
         filter_sel <= `FILTER_7M5;
         clamp_off <= 1'b0;
         curve_len <= 4'h0;
         curve_wptr <= 4'h0;
         soft_sync <= 1'b0;
      end else begin
         soft_sync <= 1'b0;
         if (wr_en) begin
            case (wr_addr)
               `REG_CONTROL: begin
                  soft_reset <= wr_data[`CTRL_SOFT_RESET_BIT];
               end
               `REG_FRONT_END: begin
                  filter_sel <= (wr_data[1:0] == 2'h3) ? `FILTER_14M : wr_data[1:0];
                  clamp_off <= wr_data[`FE_CLAMP_OFF_BIT];
               end
               `REG_CURVE_CTRL: begin
                  soft_sync <= wr_data[`CURVE_SYNC_BIT];
                  curve_len <= wr_data[7:4];
                  curve_wptr <= wr_data[11:8];
               end
               `REG_CURVE_DATA: begin
                  curve_wptr <= curve_wptr + 4'h1;
               end
               default: begin
                  soft_sync <= 1'b0;
               end
            endcase
         end
      end
   end

   // curve memory, no reset needed
   always @(posedge aclk) begin
      if (wr_en && (wr_addr == `REG_CURVE_DATA)) begin
         curve_mem[curve_wptr] <= (wr_data[8:0] > `GAIN_CODE_MAX) ? `GAIN_CODE_MAX : wr_data[8:0];
      end
   end

   // -----------------------------------------------------------------
   // curve stepping
   // -----------------------------------------------------------------
   wire sync_event;
   assign sync_event = sync_rise | soft_sync;

   always @(posedge aclk) begin
      if (!aresetn || regs_clear) begin
         curve_pos <= 4'h0;
         curve_run <= 1'b0;
         gain_code <= 9'h000;
      end else if (sync_event) begin
         curve_pos <= 4'h0;
         curve_run <= 1'b1;
         gain_code <= curve_mem[0];
      end else if (curve_run) begin
         gain_code <= curve_mem[curve_pos];
         if (curve_pos == curve_len) begin
            curve_run <= 1'b0;
         end else begin
            curve_pos <= curve_pos + 4'h1;
         end
      end
   end

   // front-end control outputs
   always @(posedge aclk) begin
      if (!aresetn) begin
         antialias_filter <= `FILTER_7M5;
         clamp_enable <= 1'b1;
      end else begin
         antialias_filter <= filter_sel;
         clamp_enable <= ~clamp_off;
      end
   end

   // -----------------------------------------------------------------
   // pair interleave and conversion latency
   // -----------------------------------------------------------------
   reg phase; // which stage of each pair samples
   reg [95:0] lat_pipe [0:`CONV_LATENCY-1]; // latency line
   reg [`CONV_LATENCY-1:0] lat_valid;
   integer i;

   always @(posedge aclk) begin
      if (!aresetn) begin
         phase <= 1'b0;
         stage_gain_active <= 16'h5555;
      end else begin
         phase <= ~phase;
         stage_gain_active <= phase ? 16'h5555 : 16'haaaa;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         lat_valid <= 11'h000;
      end else begin
         lat_valid <= {lat_valid[`CONV_LATENCY-2:0], 1'b1};
      end
      lat_pipe[0] <= conv_in;
      for (i = 1; i < `CONV_LATENCY; i = i + 1) begin
         lat_pipe[i] <= lat_pipe[i-1];
      end
   end

   // -----------------------------------------------------------------
   // fifo and serializer
   // -----------------------------------------------------------------
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [95:0] fifo_out_data;
   wire [4:0] fifo_level;
   reg ser_take; // serializer pulls a word

   word_fifo #(
      .WIDTH(96),
      .DEPTH(`FIFO_DEPTH),
      .AW(`FIFO_AW)
   ) u_fifo (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_valid(lat_valid[`CONV_LATENCY-1] & phase),
      .in_ready(fifo_in_ready),
      .in_data(lat_pipe[`CONV_LATENCY-1]),
      .out_valid(fifo_out_valid),
      .out_ready(ser_take),
      .out_data(fifo_out_data),
      .level(fifo_level)
   );

   reg [95:0] out_shift; // words being shifted
   reg [3:0] out_bit; // bit position in word
   reg out_half; // bit clock half
   reg out_busy;
   reg drop_flag; // sticky: word lost, fifo full
   integer k;

   always @* begin
      ser_take = fifo_out_valid & (~out_busy | (out_half && out_bit == 4'hb));
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         out_shift <= 96'h0;
         out_bit <= 4'h0;
         out_half <= 1'b0;
         out_busy <= 1'b0;
         data_lane <= 8'h00;
         bit_clk <= 1'b0;
         frame_clk <= 1'b0;
      end else if (ser_take) begin
         out_shift <= fifo_out_data;
         out_busy <= 1'b1;
         out_bit <= 4'h0;
         out_half <= 1'b0;
         bit_clk <= 1'b0;
         frame_clk <= 1'b1;
         for (k = 0; k < 8; k = k + 1) begin
            // offset binary, msb first
            data_lane[k] <= fifo_out_data[k*12+11];
         end
      end else if (out_busy) begin
         out_half <= ~out_half;
         bit_clk <= ~out_half;
         if (out_half) begin
            if (out_bit == 4'hb) begin
               out_busy <= 1'b0;
               frame_clk <= 1'b0;
            end else begin
               out_bit <= out_bit + 4'h1;
               frame_clk <= (out_bit < 4'h5);
               for (k = 0; k < 8; k = k + 1) begin
                  data_lane[k] <= out_shift[k*12+10-out_bit];
               end
            end
         end
      end
   end

   // overflow flag, set wins over clear
   always @(posedge aclk) begin
      if (!aresetn) begin
         drop_flag <= 1'b0;
      end else if (lat_valid[`CONV_LATENCY-1] && phase && !fifo_in_ready) begin
         drop_flag <= 1'b1;
      end else if (s_arvalid && s_arready && s_araddr[7:2] == `REG_FIFO_STATUS) begin
         drop_flag <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // axi read
   // -----------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_rvalid <= 1'b0;
         s_rdata <= 32'h00000000;
         s_rresp <= 2'h0;
      end else if (s_arvalid && s_arready) begin
         s_rvalid <= 1'b1;
         s_rresp <= 2'h0;
         case (s_araddr[7:2])
            `REG_FRONT_END: s_rdata <= {29'h0, clamp_off, filter_sel};
            `REG_CURVE_CTRL: s_rdata <= {20'h0, curve_wptr, curve_len, 4'h0};
            `REG_CURVE_STATUS: s_rdata <= {23'h0, curve_run, curve_pos, 4'h0};
            `REG_GAIN_NOW: s_rdata <= {23'h0, gain_code};
            `REG_FIFO_STATUS: s_rdata <= {26'h0, drop_flag, fifo_level};
            `REG_CONTROL: s_rdata <= {31'h0, soft_reset};
            default: begin
               s_rdata <= 32'h00000000;
               s_rresp <= 2'h2;
            end
         endcase
      end else if (s_rvalid && s_rready) begin
         s_rvalid <= 1'b0;
      end
   end
endmodule // vga_adc_gain_sequencing_serial_out

//--- verilog/vga_adc_regs.vh
/*
 * constants of the gain sequencing and serial output block:
 * serial word layout, register addresses, field positions, timing counts.
 * assumes inclusion by bare name from the design files.
 */
`ifndef VGA_ADC_REGS_VH
`define VGA_ADC_REGS_VH

// -----------------------------------------------------------------
// serial programming word
// -----------------------------------------------------------------
`define SER_WORD_BITS 24
`define SER_ADDR_BITS 8
`define SER_DATA_BITS 16

// -----------------------------------------------------------------
// register addresses (serial and axi word index)
// -----------------------------------------------------------------
`define REG_CONTROL 8'h00
`define REG_FRONT_END 8'h01
`define REG_CURVE_CTRL 8'h02
`define REG_CURVE_DATA 8'h03
`define REG_CURVE_STATUS 8'h04
`define REG_GAIN_NOW 8'h05
`define REG_FIFO_STATUS 8'h06

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define CTRL_SOFT_RESET_BIT 0
`define FE_FILTER_LSB 0
`define FE_CLAMP_OFF_BIT 2
`define CURVE_SYNC_BIT 0
`define CURVE_PTR_LSB 8
`define CURVE_LEN_LSB 4

// antialias_filter corner codes
`define FILTER_7M5 2'h0
`define FILTER_10M 2'h1
`define FILTER_14M 2'h2

// -----------------------------------------------------------------
// gain code: -5 dB .. 31 dB in 0.125 dB steps -> 0 .. 288
// -----------------------------------------------------------------
`define GAIN_BITS 9
`define GAIN_CODE_MAX 9'h120
`define CURVE_DEPTH 16
`define CURVE_AW 4

// -----------------------------------------------------------------
// conversion and serial output timing
// -----------------------------------------------------------------
`define CONV_BITS 12
`define CONV_LATENCY 11
`define CHANNELS 8
`define STAGES 16
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define RESET_VALUE 16'h0000

`endif

//--- verilog/word_fifo.v
/*
 * word_fifo: synchronous fifo, parameter width and depth,
 * valid/ready on both sides.
 * assumes one clock, synchronous active-low reset.
 */
`timescale 1ns/1ps

module word_fifo #(
   parameter WIDTH = 96,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire aclk,
   input wire aresetn,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data,
   output wire [AW:0] level
);
   // storage array
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_ptr; // write pointer, extra wrap bit
   reg [AW:0] rd_ptr; // read pointer, extra wrap bit
   wire push;
   wire pop;

   // -----------------------------------------------------------------
   // flags
   // -----------------------------------------------------------------
   assign level = wr_ptr - rd_ptr;
   assign in_ready = (level != DEPTH[AW:0]);
   assign out_valid = (level != {(AW+1){1'b0}});
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rd_ptr[AW-1:0]];

   // write side
   always @(posedge aclk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   // pointer update
   always @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule // word_fifo

//--- verif/vga_adc_checker.sv
/*
 * checker: port-level timing of pair sampling, gain range, filter code,
 * frame and bit clocks, and the reset pin.
 * assumes binding to vga_adc_gain_sequencing_serial_out on aclk.
 */
`timescale 1ns/1ps

module vga_adc_checker (
   input wire aclk,
   input wire aresetn,
   input wire reset_pin,
   input wire [15:0] stage_gain_active,
   input wire [8:0] gain_code,
   input wire [1:0] antialias_filter,
   input wire clamp_enable,
   input wire bit_clk,
   input wire frame_clk
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ----------------------------------------
   // pair sampling and gain
   // ----------------------------------------
   a_pair_alternate: assert property ($past(aresetn) |-> stage_gain_active == ~$past(stage_gain_active))
      else $error("stage select did not alternate");
   a_pair_legal: assert property (stage_gain_active == 16'h5555 || stage_gain_active == 16'haaaa)
      else $error("stage select not a fixed pair pattern");
   a_gain_range: assert property (gain_code <= 9'h120)
      else $error("gain code above top of range");
   a_filter_code: assert property (antialias_filter != 2'h3)
      else $error("filter corner code invalid");

   // ----------------------------------------
   // serial output framing
   // ----------------------------------------
   a_frame_high: assert property ($rose(frame_clk) |-> frame_clk [*8] ##1 frame_clk [*4] ##1 !frame_clk)
      else $error("frame high phase not six bits");
   a_frame_low: assert property ($fell(frame_clk) |-> !frame_clk [*8] ##1 !frame_clk [*4])
      else $error("frame low phase too short");
   a_bit_toggle: assert property (frame_clk && $past(frame_clk) |-> bit_clk != $past(bit_clk))
      else $error("bit clock stalled within frame");

   // ----------------------------------------
   // reset pin clears controls
   // ----------------------------------------
   a_pin_clears: assert property (reset_pin [*4] |=> antialias_filter == 2'h0 && clamp_enable)
      else $error("reset pin left controls set");
endmodule // vga_adc_checker

bind vga_adc_gain_sequencing_serial_out vga_adc_checker chk_i (
   .aclk(aclk), .aresetn(aresetn), .reset_pin(reset_pin), .stage_gain_active(stage_gain_active),
   .gain_code(gain_code), .antialias_filter(antialias_filter), .clamp_enable(clamp_enable),
   .bit_clk(bit_clk), .frame_clk(frame_clk));

//--- verif/far_side.sv
/*
 * far_side: serial programming host and a receiver for two output lanes.
 * assumes a 160 ns link clock that stands still between words.
 */
`timescale 1ns/1ps

module far_side (
   input wire aclk,
   input wire frame_clk,
   input wire [7:0] data_lane,
   output logic serial_clk,
   output logic serial_select_n,
   output logic serial_shift_data
);
   // idle levels: select pulled up, clock and data pulled down
   initial begin
      serial_clk = 1'b0;
      serial_select_n = 1'b1;
      serial_shift_data = 1'b0;
   end

   task send(input logic [7:0] a, input logic [15:0] d);
      logic [23:0] w;
      w = {a, d};
      #3 serial_select_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         serial_shift_data = w[i];
         #80 serial_clk = 1'b1;
         #80 serial_clk = 1'b0;
      end
      #40 serial_select_n = 1'b1;
      serial_shift_data = 1'b0;
   endtask

   // collect one word of lanes 0 and 7, two aclk per bit
   task rx(output logic [11:0] w0, output logic [11:0] w7, output logic ok);
      int n;
      n = 0;
      while (frame_clk && n < 100) begin
         @(posedge aclk);
         n++;
      end
      while (!frame_clk && n < 100) begin
         @(posedge aclk);
         n++;
      end
      ok = (n < 100);
      for (int i = 0; i < 12; i++) begin
         w0 = {w0[10:0], data_lane[0]};
         w7 = {w7[10:0], data_lane[7]};
         repeat (2) @(posedge aclk);
      end
   endtask
endmodule // far_side

//--- verif/vga_adc_gain_sequencing_serial_out_tb.sv
/*
 * testbench: register rows over axi4-lite, curve sync, resets, serial
 * programming, lane words and fifo overflow.
 * assumes far_side and the bound checker.
 */
`timescale 1ns/1ps

module vga_adc_gain_sequencing_serial_out_tb;
   logic aclk, aresetn, reset_pin, sync_pin;
   logic [95:0] conv_in;
   logic [7:0] s_awaddr, s_araddr;
   logic [31:0] s_wdata, d;
   logic [3:0] s_wstrb;
   logic s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, ok;
   wire s_awready, s_wready, s_bvalid, s_arready, s_rvalid, sclk, ssel_n, sdat, bit_clk, frame_clk, clamp_enable;
   wire [1:0] s_bresp, s_rresp, antialias_filter;
   wire [31:0] s_rdata;
   wire [7:0] data_lane;
   wire [15:0] stage_gain_active;
   wire [8:0] gain_code;
   logic [1:0] r;
   logic [11:0] w0, w7;
   int n_fail, checked;
   typedef struct packed {logic [7:0] a; logic [31:0] d, rd; logic [1:0] br, f; logic c;} row_t;
   row_t rows[5] = '{'{8'h04, 32'h0, 32'h0, 2'h0, 2'h0, 1'b1}, '{8'h04, 32'h1, 32'h1, 2'h0, 2'h1, 1'b1},
      '{8'h04, 32'h6, 32'h6, 2'h0, 2'h2, 1'b0}, '{8'h04, 32'h3, 32'h2, 2'h0, 2'h2, 1'b1},
      '{8'h1c, 32'h5, 32'h0, 2'h2, 2'h2, 1'b1}};

   vga_adc_gain_sequencing_serial_out DUT (.aclk(aclk), .aresetn(aresetn), .reset_pin(reset_pin),
      .sync_pin(sync_pin), .serial_clk(sclk), .serial_select_n(ssel_n), .serial_shift_data(sdat),
      .conv_in(conv_in), .data_lane(data_lane), .bit_clk(bit_clk), .frame_clk(frame_clk),
      .stage_gain_active(stage_gain_active), .gain_code(gain_code), .antialias_filter(antialias_filter),
      .clamp_enable(clamp_enable), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
      .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
      .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
      .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));
   far_side far (.aclk(aclk), .frame_clk(frame_clk), .data_lane(data_lane), .serial_clk(sclk),
      .serial_select_n(ssel_n), .serial_shift_data(sdat));

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task final_report;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
         n_fail++;
      end
   endtask

   task stuck;
      n_fail++;
      final_report;
   endtask

   // axi write: address and data together, hold bready to the answer
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_awaddr <= a; s_wdata <= v; s_awvalid <= 1'b1; s_wvalid <= 1'b1; s_bready <= 1'b1;
      repeat (50) begin
         @(posedge aclk);
         if (s_awvalid && s_awready) s_awvalid <= 1'b0;
         if (s_wvalid && s_wready) s_wvalid <= 1'b0;
         if (s_bvalid) begin
            r = s_bresp; s_bready <= 1'b0;
            return;
         end
      end
      stuck;
   endtask

   task rd(input logic [7:0] a);
      @(posedge aclk);
      s_araddr <= a; s_arvalid <= 1'b1; s_rready <= 1'b1;
      repeat (50) begin
         @(posedge aclk);
         if (s_arvalid && s_arready) s_arvalid <= 1'b0;
         if (s_rvalid) begin
            d = s_rdata; r = s_rresp; s_rready <= 1'b0;
            return;
         end
      end
      stuck;
   endtask

   // start the curve by pin or by register, then follow its steps
   task curve(input logic sw);
      int n;
      if (sw) wr(8'h08, 32'h31);
      else begin
         @(posedge aclk); sync_pin <= 1'b1;
         repeat (3) @(posedge aclk);
         sync_pin <= 1'b0;
      end
      for (n = 0; n < 60 && gain_code !== 9'h014; n++) @(posedge aclk);
      if (n == 60) stuck;
      @(posedge aclk); chk(gain_code, 9'h01e);
      @(posedge aclk); chk(gain_code, 9'h120);
      @(posedge aclk); chk(gain_code, 9'h120);
      rd(8'h14); chk(d, 32'h120);
   endtask

   initial begin
      n_fail = 0; checked = 0; aresetn = 1'b0; reset_pin = 1'b0; sync_pin = 1'b0;
      s_awaddr = 8'h00; s_araddr = 8'h00; s_wdata = 32'h0; s_wstrb = 4'hf;
      s_awvalid = 1'b0; s_wvalid = 1'b0; s_bready = 1'b0; s_arvalid = 1'b0; s_rready = 1'b0;
      conv_in = {12'h3c1, 72'h0, 12'ha5c};
      repeat (10) @(posedge aclk);
      chk(stage_gain_active, 16'h5555);
      aresetn <= 1'b1;
      @(posedge aclk); #1;
      chk({antialias_filter, clamp_enable}, 3'h1);
      // table of register rows, unmapped word last
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d); chk(r, rows[i].br);
         rd(rows[i].a); chk(d, rows[i].rd);
         chk(r, rows[i].br);
         chk({antialias_filter, clamp_enable}, {rows[i].f, rows[i].c});
      end
      // curve of four entries, last above range
      wr(8'h08, 32'h30);
      wr(8'h0c, 32'h0a); wr(8'h0c, 32'h14); wr(8'h0c, 32'h1e); wr(8'h0c, 32'h1ff);
      curve(1'b0);
      curve(1'b1);
      // soft reset then self-clear
      wr(8'h00, 32'h1);
      rd(8'h00); chk(d, 32'h0);
      rd(8'h04); chk(d, 32'h0);
      // reset pin pulse
      wr(8'h04, 32'h6);
      @(posedge aclk); reset_pin <= 1'b1;
      repeat (6) @(posedge aclk);
      reset_pin <= 1'b0;
      rd(8'h04); chk(d, 32'h0);
      // serial programming of the filter register
      far.send(8'h01, 16'h0002);
      repeat (200) if (antialias_filter !== 2'h2) @(posedge aclk);
      rd(8'h04); chk(d, 32'h2);
      chk(antialias_filter, 2'h2);
      // lane words and fifo overflow
      far.rx(w0, w7, ok);
      chk(ok, 1'b1);
      chk(w0, 12'ha5c);
      chk(w7, 12'h3c1);
      rd(8'h18); chk(d[5], 1'b1);
      final_report;
   end
endmodule // vga_adc_gain_sequencing_serial_out_tb
